// >>> verilog/ccsm_clock_mode_ctrl.sv
// CPU clock source selection, standby modes and oscillator run control
//
// What this block does
// R1 - Any reset clears the source select, so the CPU starts on the internal_fast_oscillator.
// R2 - After reset release, CPU clock waits seventeen ring oscillator ticks.
// R3 - During reset both crystal and ring oscillators are held stopped.
// R4 - Writing source select moves the CPU to crystal after two crystal ticks.
// R5 - Status bit one of main clock mode shows the source really used.
// R6 - Ring stop works only if stoppable and CPU is on crystal or sub.
// R7 - On ring oscillator, main oscillator stop bit runs or stops crystal.
// R8 - On subsystem clock, the processor clock control bit governs crystal.
// R9 - Subsystem operation supports halt; stop requests are ignored there.
// R10 - Stop release on crystal waits the selected two-power crystal periods.
// R11 - Software polls stabilization status when resuming on ring oscillator.
// R12 - Stoppable option cuts the watchdog clock in halt and stop.
// R13 - Stoppable option keeps ring oscillator running in standby if bit zero.
// R14 - Non-stoppable option keeps watchdog counting in stop, resets on overflow.
// R15 - No direct switch between subsystem and ring; pass through crystal.
// R16 - Pin, power-on, low voltage, clock monitor, watchdog all reset the block.
// R17 - Halt and stop resume on the source in use when entered.
// R18 - Main osc stop at bit seven, internal_fast_oscillator stop at bit zero.
// R19 - Reset loads stabilization select with code five.
// R20 - Source status changes only when the clock mux finished switching.
`timescale 1ns/1ps
`default_nettype none
module ccsm_clock_mode_ctrl #(
  parameter bit RING_STOPPABLE = 1'b1,
  parameter int WDOG_WIDTH     = 10
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic [7:0]      regRdData,
  // Reset sources, active high levels
  input  wire logic       pinResetReq,
  input  wire logic       powerOnClear,
  input  wire logic       lowVoltageDetect,
  input  wire logic       clockMonitorFail,
  // Oscillator ticks, one cycle per oscillator period
  input  wire logic       ringTick,
  input  wire logic       xtalTick,
  input  wire logic       subTick,
  // CPU standby requests
  input  wire logic       haltReq,
  input  wire logic       stopReq,
  input  wire logic       wakeReq,
  // Clock and oscillator control
  output logic            cpuClkEn,
  output logic            ringOscEn,
  output logic            mainOscEn,
  output logic            wdogClkEn,
  output logic            wdogReset,
  output logic [2:0]      cpuMode
);

  ccsm_pkg::ccsm_state_t state_q;
  ccsm_pkg::ccsm_state_t state_d;

  logic [4:0]           startCnt_q;
  logic [4:0]           startCnt_d;
  logic                 srcSel_q;
  logic                 srcSel_d;
  logic                 srcStat_q;
  logic                 srcStat_d;
  logic                 css_q;
  logic                 css_d;
  logic                 cls_q;
  logic                 cls_d;
  logic [1:0]           swCnt_q;
  logic [1:0]           swCnt_d;
  logic                 ringStop_q;
  logic                 ringStop_d;
  logic                 mainStop_q;
  logic                 mainStop_d;
  logic                 subXStop_q;
  logic                 subXStop_d;
  logic [2:0]           stabSel_q;
  logic [2:0]           stabSel_d;
  logic [WDOG_WIDTH-1:0] wdogCnt_q;
  logic [WDOG_WIDTH-1:0] wdogCnt_d;
  logic                 wdogOvf_q;
  logic                 wdogOvf_d;
  logic [7:0]           rdData_q;
  logic [7:0]           rdData_d;
  logic                 cpuClkEn_q;
  logic                 cpuClkEn_d;
  logic                 ringEn_q;
  logic                 ringEn_d;
  logic                 mainEn_q;
  logic                 mainEn_d;
  logic                 wdogEn_q;
  logic                 wdogEn_d;

  logic                         rstInt;
  logic                         ringOk;
  logic                         xtalOk;
  logic                         pendMain;
  logic                         pendSub;
  logic                         tgtTick;
  logic                         curTick;
  logic                         standby;
  logic [ccsm_pkg::STAB_W-1:0]  stabCount;
  logic [ccsm_pkg::STAB_NUM-1:0] stabStat;
  logic                         stabReached;

  // R16 all sources reset
  assign rstInt = !resetn || pinResetReq || powerOnClear ||
                  lowVoltageDetect || clockMonitorFail || wdogOvf_q;

  // Ticks only count while the oscillator is really enabled
  assign ringOk  = ringTick && ringEn_q;
  assign xtalOk  = xtalTick && mainEn_q;
  assign standby = (state_q == ccsm_pkg::ST_HALT) ||
                   (state_q == ccsm_pkg::ST_STOP) ||
                   (state_q == ccsm_pkg::ST_STABW);

  ccsm_stab_counter #(
    .WIDTH (ccsm_pkg::STAB_W)
  ) u_stab (
    .clock   (clock),
    .resetn  (resetn),
    .restart (!mainEn_q),
    .tick    (xtalOk),
    .count   (stabCount)
  );

  // Stabilization status and the wait chosen for stop release
  always_comb begin
    stabStat    = '0;
    stabReached = 1'b0;
    for (int i = 0; i < ccsm_pkg::STAB_NUM; i++) begin
      stabStat[i] = stabCount >=
                    (ccsm_pkg::STAB_W'(1) << ccsm_pkg::STAB_EXP[i]);
    end
    // R10 selected wait length
    case (stabSel_q)
      3'h1:    stabReached = stabStat[0];
      3'h2:    stabReached = stabStat[1];
      3'h3:    stabReached = stabStat[2];
      3'h4:    stabReached = stabStat[3];
      // Prohibited codes fall back to the longest wait
      default: stabReached = stabStat[4];
    endcase
  end

  // Source switching and operating status
  always_comb begin
    state_d    = state_q;
    startCnt_d = startCnt_q;
    srcSel_d   = srcSel_q;
    srcStat_d  = srcStat_q;
    css_d      = css_q;
    cls_d      = cls_q;
    swCnt_d    = swCnt_q;
    pendMain   = srcSel_q != srcStat_q;
    pendSub    = css_q != cls_q;
    tgtTick    = pendMain ? (srcSel_q ? xtalOk : ringOk)
                          : (css_q ? subTick : xtalOk);
    curTick    = cls_q ? subTick : (srcStat_q ? xtalOk : ringOk);

    if (regWrite && regAddr == ccsm_pkg::MODE_ADDR) begin
      // R15 no ring select while subsystem is in use
      if (!cls_q && !css_q) begin
        // R4 software source select
        srcSel_d = regWrData[ccsm_pkg::MODE_SEL_BIT];
      end
    end
    if (regWrite && regAddr == ccsm_pkg::PCLK_ADDR) begin
      if (!regWrData[ccsm_pkg::PCLK_CSS_BIT]) begin
        css_d = 1'b0;
      end else if (srcStat_q && srcSel_q && !pendMain) begin
        // R15 subsystem only entered from crystal
        css_d = 1'b1;
      end
    end

    // R20 status follows the mux, not the write; R17 frozen in standby
    if (state_q == ccsm_pkg::ST_RUN && (pendMain || pendSub)) begin
      if (tgtTick) begin
        if (swCnt_q == ccsm_pkg::SWITCH_TICKS - 2'h1) begin
          swCnt_d = 2'h0;
          if (pendMain) begin
            // R5 actual source reported
            srcStat_d = srcSel_q;
          end else begin
            cls_d = css_q;
          end
        end else begin
          swCnt_d = swCnt_q + 2'h1;
        end
      end
    end else begin
      swCnt_d = 2'h0;
    end

    case (state_q)
      ccsm_pkg::ST_RESET: begin
        startCnt_d = 5'h00;
        state_d    = ccsm_pkg::ST_START;
      end
      ccsm_pkg::ST_START: begin
        // R2 hold CPU clock for seventeen ring ticks
        if (ringOk) begin
          if (startCnt_q == ccsm_pkg::START_TICKS - 5'h01) begin
            state_d = ccsm_pkg::ST_RUN;
          end else begin
            startCnt_d = startCnt_q + 5'h01;
          end
        end
      end
      ccsm_pkg::ST_RUN: begin
        // R9 stop is unavailable on the subsystem clock
        if (stopReq && !cls_q && !css_q) begin
          state_d = ccsm_pkg::ST_STOP;
        end else if (haltReq) begin
          state_d = ccsm_pkg::ST_HALT;
        end
      end
      ccsm_pkg::ST_HALT: begin
        if (wakeReq) begin
          state_d = ccsm_pkg::ST_RUN;
        end
      end
      ccsm_pkg::ST_STOP: begin
        // R11 on ring the CPU resumes at once; software polls status
        if (wakeReq) begin
          state_d = srcStat_q ? ccsm_pkg::ST_STABW : ccsm_pkg::ST_RUN;
        end
      end
      ccsm_pkg::ST_STABW: begin
        // R10 crystal wait before resuming
        if (stabReached) begin
          state_d = ccsm_pkg::ST_RUN;
        end
      end
      default: state_d = ccsm_pkg::ST_RESET;
    endcase

    cpuClkEn_d = (state_q == ccsm_pkg::ST_RUN) && curTick;
  end

  always_ff @(posedge clock) begin
    if (rstInt) begin
      state_q    <= ccsm_pkg::ST_RESET;
      startCnt_q <= 5'h00;
      // R1 select back to ring oscillator
      srcSel_q   <= ccsm_pkg::SEL_RESET;
      srcStat_q  <= ccsm_pkg::SEL_RESET;
      css_q      <= 1'b0;
      cls_q      <= 1'b0;
      swCnt_q    <= 2'h0;
      cpuClkEn_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      startCnt_q <= startCnt_d;
      srcSel_q   <= srcSel_d;
      srcStat_q  <= srcStat_d;
      css_q      <= css_d;
      cls_q      <= cls_d;
      swCnt_q    <= swCnt_d;
      cpuClkEn_q <= cpuClkEn_d;
    end
  end

  // Control registers, oscillator enables and watchdog
  always_comb begin
    ringStop_d = ringStop_q;
    mainStop_d = mainStop_q;
    subXStop_d = subXStop_q;
    stabSel_d  = stabSel_q;
    wdogCnt_d  = wdogCnt_q;
    wdogOvf_d  = 1'b0;
    rdData_d   = 8'h00;

    if (regWrite) begin
      // R18 stop bit positions
      if (regAddr == ccsm_pkg::RING_ADDR) begin
        ringStop_d = regWrData[ccsm_pkg::RING_STOP_BIT];
      end else if (regAddr == ccsm_pkg::XOSC_ADDR) begin
        mainStop_d = regWrData[ccsm_pkg::XOSC_STOP_BIT];
      end else if (regAddr == ccsm_pkg::PCLK_ADDR) begin
        subXStop_d = regWrData[ccsm_pkg::PCLK_XSTOP_BIT];
      end else if (regAddr == ccsm_pkg::WSEL_ADDR) begin
        stabSel_d = regWrData[2:0];
      end else if (regAddr == ccsm_pkg::WDCLR_ADDR) begin
        wdogCnt_d = '0;
      end
    end

    if (regRead) begin
      if (regAddr == ccsm_pkg::MODE_ADDR) begin
        rdData_d[ccsm_pkg::MODE_SEL_BIT]  = srcSel_q;
        rdData_d[ccsm_pkg::MODE_STAT_BIT] = srcStat_q;
      end else if (regAddr == ccsm_pkg::RING_ADDR) begin
        rdData_d[ccsm_pkg::RING_STOP_BIT] = ringStop_q;
      end else if (regAddr == ccsm_pkg::XOSC_ADDR) begin
        rdData_d[ccsm_pkg::XOSC_STOP_BIT] = mainStop_q;
      end else if (regAddr == ccsm_pkg::PCLK_ADDR) begin
        rdData_d[ccsm_pkg::PCLK_XSTOP_BIT] = subXStop_q;
        rdData_d[ccsm_pkg::PCLK_CLS_BIT]   = cls_q;
        rdData_d[ccsm_pkg::PCLK_CSS_BIT]   = css_q;
      end else if (regAddr == ccsm_pkg::WSEL_ADDR) begin
        rdData_d[2:0] = stabSel_q;
      end else if (regAddr == ccsm_pkg::WSTA_ADDR) begin
        rdData_d[ccsm_pkg::STAB_NUM-1:0] = stabStat;
      end
    end

    // R3 reset holds oscillators off; R6 R13 ring stop gating
    ringEn_d = !rstInt &&
               !(RING_STOPPABLE && ringStop_q && (srcStat_q || cls_q));
    // Crystal is off in stop; in run the bit that rules it depends on source
    mainEn_d = !rstInt && (state_q != ccsm_pkg::ST_STOP);
    if (cls_q || css_q) begin
      // R8 processor clock control rules crystal
      mainEn_d = mainEn_d && !subXStop_q;
    end else if (!srcStat_q && !srcSel_q) begin
      // R7 main stop bit rules crystal
      mainEn_d = mainEn_d && !mainStop_q;
    end

    // R12 watchdog clock cut in standby; R14 keeps counting otherwise
    wdogEn_d = !rstInt && !(RING_STOPPABLE && standby);
    if (ringOk && wdogEn_q) begin
      if (&wdogCnt_q) begin
        // R14 overflow wins over a clear in the same cycle
        wdogOvf_d = 1'b1;
        wdogCnt_d = '0;
      end else if (!(regWrite && regAddr == ccsm_pkg::WDCLR_ADDR)) begin
        wdogCnt_d = wdogCnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rstInt) begin
      ringStop_q <= 1'b0;
      mainStop_q <= 1'b0;
      subXStop_q <= 1'b0;
      // R19 code five, which falls back to the longest wait
      stabSel_q  <= ccsm_pkg::WSEL_RESET;
      wdogCnt_q  <= '0;
      wdogOvf_q  <= 1'b0;
      rdData_q   <= 8'h00;
      ringEn_q   <= 1'b0;
      mainEn_q   <= 1'b0;
      wdogEn_q   <= 1'b0;
    end else begin
      ringStop_q <= ringStop_d;
      mainStop_q <= mainStop_d;
      subXStop_q <= subXStop_d;
      stabSel_q  <= stabSel_d;
      wdogCnt_q  <= wdogCnt_d;
      wdogOvf_q  <= wdogOvf_d;
      rdData_q   <= rdData_d;
      ringEn_q   <= ringEn_d;
      mainEn_q   <= mainEn_d;
      wdogEn_q   <= wdogEn_d;
    end
  end

  assign regRdData = rdData_q;
  assign cpuClkEn  = cpuClkEn_q;
  assign ringOscEn = ringEn_q;
  assign mainOscEn = mainEn_q;
  assign wdogClkEn = wdogEn_q;
  assign wdogReset = wdogOvf_q;
  assign cpuMode   = state_q;

endmodule
`default_nettype wire

// >>> verilog/ccsm_pkg.sv
// Constants, register map and state encoding of the CPU clock control
package ccsm_pkg;

  // Register index on the local port (byte wide registers)
  localparam logic [3:0] MODE_ADDR  = 4'h0;
  localparam logic [3:0] RING_ADDR  = 4'h1;
  localparam logic [3:0] XOSC_ADDR  = 4'h2;
  localparam logic [3:0] PCLK_ADDR  = 4'h3;
  localparam logic [3:0] WSEL_ADDR  = 4'h4;
  localparam logic [3:0] WSTA_ADDR  = 4'h5;
  localparam logic [3:0] WDCLR_ADDR = 4'h6;

  // Field positions
  localparam int MODE_SEL_BIT   = 0;
  localparam int MODE_STAT_BIT  = 1;
  localparam int RING_STOP_BIT  = 0;
  localparam int XOSC_STOP_BIT  = 7;
  localparam int PCLK_XSTOP_BIT = 7;
  localparam int PCLK_CLS_BIT   = 5;
  localparam int PCLK_CSS_BIT   = 4;

  // Values after reset
  localparam logic [2:0] WSEL_RESET = 3'h5;
  localparam logic       SEL_RESET  = 1'b0;

  // Counts in oscillator periods
  localparam logic [4:0] START_TICKS  = 5'h11;
  localparam logic [1:0] SWITCH_TICKS = 2'h2;
  localparam int         STAB_NUM     = 5;
  localparam int         STAB_W       = 17;
  localparam int         STAB_EXP [STAB_NUM] = '{11, 13, 14, 15, 16};

  // Operating status, Gray along reset, start, run, halt, stop, wait
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_START = 3'h1,
    ST_RUN   = 3'h3,
    ST_HALT  = 3'h2,
    ST_STOP  = 3'h6,
    ST_STABW = 3'h7
  } ccsm_state_t;

endpackage

// >>> verilog/ccsm_stab_counter.sv
// Crystal stabilization counter, saturating in crystal periods
`timescale 1ns/1ps
`default_nettype none
module ccsm_stab_counter #(
  parameter int WIDTH = ccsm_pkg::STAB_W
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Counting control
  input  wire logic             restart,
  input  wire logic             tick,
  // Elapsed crystal periods
  output logic [WIDTH-1:0]      count
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // Saturates once the top bit is reached so the longest wait stays seen
  always_comb begin
    count_d = count_q;
    if (restart) begin
      count_d = '0;
    end else if (tick && !count_q[WIDTH-1]) begin
      count_d = count_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule
`default_nettype wire

// >>> sim/ccsm_clock_mode_ctrl_properties.sv
// Port level checks of the CPU clock mode control
`timescale 1ns/1ps
`default_nettype none
module ccsm_clock_mode_ctrl_checker #(
  parameter bit RING_STOPPABLE = 1'b1,
  parameter int WDOG_WIDTH     = 10
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // Register port
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  // Reset sources and ticks
  input wire logic       pinResetReq,
  input wire logic       powerOnClear,
  input wire logic       lowVoltageDetect,
  input wire logic       clockMonitorFail,
  input wire logic       ringTick,
  // Clock control outputs
  input wire logic       cpuClkEn,
  input wire logic       ringOscEn,
  input wire logic       mainOscEn,
  input wire logic       wdogClkEn,
  input wire logic       wdogReset,
  input wire logic [2:0] cpuMode
);
  logic [4:0]  startCnt_q;
  logic [4:0]  startCnt_d;
  logic [16:0] stabCnt_q;
  logic [16:0] stabCnt_d;

  // Ring ticks seen while starting, cycles spent in the stabilization wait
  always_comb begin
    startCnt_d = startCnt_q;
    stabCnt_d  = 17'h00000;
    if (cpuMode == ccsm_pkg::ST_RESET)
      startCnt_d = 5'h00;
    else if (cpuMode == ccsm_pkg::ST_START && ringTick && ringOscEn)
      startCnt_d = startCnt_q + 5'h01;
    if (cpuMode == ccsm_pkg::ST_STABW)
      stabCnt_d = stabCnt_q + 17'h00001;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      startCnt_q <= 5'h00;
      stabCnt_q  <= 17'h00000;
    end else begin
      startCnt_q <= startCnt_d;
      stabCnt_q  <= stabCnt_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Must fire while reset is held, so it has no disable condition
  property p_resetOff;
    disable iff (1'b0) !resetn |=> !ringOscEn && !mainOscEn;
  endproperty
  a_resetOff: assert property (p_resetOff)
    else $error("oscillator enabled during reset");

  property p_srcReset;
    (pinResetReq || powerOnClear || lowVoltageDetect || clockMonitorFail)
      |=> cpuMode == ccsm_pkg::ST_RESET;
  endproperty
  a_srcReset: assert property (p_srcReset)
    else $error("reset source ignored");

  property p_wdogRst;
    wdogReset |=> cpuMode == ccsm_pkg::ST_RESET;
  endproperty
  a_wdogRst: assert property (p_wdogRst)
    else $error("watchdog overflow did not reset");

  property p_startHold;
    cpuMode == ccsm_pkg::ST_START |-> !cpuClkEn;
  endproperty
  a_startHold: assert property (p_startHold)
    else $error("cpu clock during start");

  property p_startCnt;
    cpuMode == ccsm_pkg::ST_RUN && $past(cpuMode) == ccsm_pkg::ST_START
      |-> startCnt_q >= 5'h11;
  endproperty
  a_startCnt: assert property (p_startCnt)
    else $error("run entered before seventeen ring ticks");

  property p_startLate;
    cpuMode == ccsm_pkg::ST_START |-> startCnt_q <= 5'h12;
  endproperty
  a_startLate: assert property (p_startLate)
    else $error("start held too long");

  property p_haltWdog;
    (RING_STOPPABLE && cpuMode == ccsm_pkg::ST_HALT)[*2] |-> !wdogClkEn;
  endproperty
  a_haltWdog: assert property (p_haltWdog)
    else $error("watchdog clocked in halt");

  property p_stopWdog;
    (RING_STOPPABLE && cpuMode == ccsm_pkg::ST_STOP)[*2] |-> !wdogClkEn;
  endproperty
  a_stopWdog: assert property (p_stopWdog)
    else $error("watchdog clocked in stop");

  property p_stabMin;
    cpuMode == ccsm_pkg::ST_RUN && $past(cpuMode) == ccsm_pkg::ST_STABW
      |-> stabCnt_q >= 17'h00800;
  endproperty
  a_stabMin: assert property (p_stabMin)
    else $error("stabilization wait too short");

  property p_rdIdle;
    !regRead |=> regRdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside read slot");
endmodule

bind ccsm_clock_mode_ctrl ccsm_clock_mode_ctrl_checker #(
  .RING_STOPPABLE(RING_STOPPABLE),
  .WDOG_WIDTH(WDOG_WIDTH)
) u_checker (
  .clock(clock), .resetn(resetn), .regRead(regRead),
  .regRdData(regRdData), .pinResetReq(pinResetReq),
  .powerOnClear(powerOnClear), .lowVoltageDetect(lowVoltageDetect),
  .clockMonitorFail(clockMonitorFail), .ringTick(ringTick),
  .cpuClkEn(cpuClkEn), .ringOscEn(ringOscEn), .mainOscEn(mainOscEn),
  .wdogClkEn(wdogClkEn), .wdogReset(wdogReset), .cpuMode(cpuMode)
);
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench of the CPU clock mode control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clock     = 1'b0;
  logic       resetn    = 1'b0;
  logic [3:0] regAddr   = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic       regWrite  = 1'b0;
  logic       regRead   = 1'b0;
  logic [3:0] rstSrc    = 4'h0;
  logic [2:0] reqs      = 3'h0;
  logic       ringTick  = 1'b0;
  logic       xtalTick  = 1'b0;
  logic       subTick   = 1'b0;
  logic       xtalOn    = 1'b1;
  logic [2:0] tickCnt   = 3'h0;
  wire logic [7:0] regRdData;
  wire logic       cpuClkEn, ringOscEn, mainOscEn, wdogClkEn, wdogReset;
  wire logic [2:0] cpuMode;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  int k;

  ccsm_clock_mode_ctrl dut (
    .clock(clock), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .pinResetReq(rstSrc[0]),
    .powerOnClear(rstSrc[1]), .lowVoltageDetect(rstSrc[2]),
    .clockMonitorFail(rstSrc[3]), .ringTick(ringTick),
    .xtalTick(xtalTick), .subTick(subTick), .haltReq(reqs[0]),
    .stopReq(reqs[1]), .wakeReq(reqs[2]), .cpuClkEn(cpuClkEn),
    .ringOscEn(ringOscEn), .mainOscEn(mainOscEn), .wdogClkEn(wdogClkEn),
    .wdogReset(wdogReset), .cpuMode(cpuMode)
  );

  always #20 clock = ~clock;

  // Ring every 4 cycles, sub every 8, crystal every cycle when running
  always @(posedge clock) begin
    tickCnt  <= tickCnt + 3'h1;
    ringTick <= (tickCnt[1:0] == 2'h3);
    subTick  <= (tickCnt == 3'h5);
    xtalTick <= xtalOn;
  end

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite  <= 1'b0;
  endtask

  // Data is looked at only in the cycle after the read edge
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdData, exp);
  endtask

  task automatic req(input logic [2:0] v);
    @(posedge clock);
    reqs <= v;
    @(posedge clock);
    reqs <= 3'h0;
  endtask

  task automatic waitMode(input logic [2:0] m, input int lim);
    #1;
    n = 0;
    while (cpuMode !== m && n < lim) begin
      cyc(1);
      n++;
    end
    chk({5'h00, cpuMode}, {5'h00, m});
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    finish_test();
  end

  initial begin
    cyc(9);
    chkBit(ringOscEn | mainOscEn, 1'b0);
    @(posedge clock);
    resetn <= 1'b1;
    k = 0;
    n = 0;
    while (cpuMode !== ccsm_pkg::ST_RUN && n < 400) begin
      cyc(1);
      n++;
      if (ringTick === 1'b1 && ringOscEn === 1'b1)
        k++;
    end
    chkBit(k >= 17, 1'b1);
    // Ring ticks every 4 cycles, so 8 cycles hold two CPU clocks
    k = 0;
    repeat (8) begin
      cyc(1);
      if (cpuClkEn === 1'b1)
        k++;
    end
    chkBit(k == 2, 1'b1);
    rdchk(ccsm_pkg::MODE_ADDR, 8'h00);
    rdchk(ccsm_pkg::WSEL_ADDR, {5'h00, ccsm_pkg::WSEL_RESET});
    wr(4'hf, 8'hff);
    rdchk(4'hf, 8'h00);
    wr(ccsm_pkg::XOSC_ADDR, 8'h80);
    cyc(3);
    chkBit(mainOscEn, 1'b0);
    rdchk(ccsm_pkg::XOSC_ADDR, 8'h80);
    wr(ccsm_pkg::XOSC_ADDR, 8'h00);
    cyc(3);
    chkBit(mainOscEn, 1'b1);
    rdchk(ccsm_pkg::WSTA_ADDR, 8'h00);
    wr(ccsm_pkg::WDCLR_ADDR, 8'h00);
    cyc(2100);
    rdchk(ccsm_pkg::WSTA_ADDR, 8'h01);
    wr(ccsm_pkg::RING_ADDR, 8'h01);
    cyc(3);
    chkBit(ringOscEn, 1'b1);
    rdchk(ccsm_pkg::RING_ADDR, 8'h01);
    // Crystal held quiet so the status cannot flip early
    xtalOn <= 1'b0;
    wr(ccsm_pkg::MODE_ADDR, 8'h01);
    rdchk(ccsm_pkg::MODE_ADDR, 8'h01);
    xtalOn <= 1'b1;
    cyc(4);
    rdchk(ccsm_pkg::MODE_ADDR, 8'h03);
    cyc(3);
    chkBit(ringOscEn, 1'b0);
    wr(ccsm_pkg::RING_ADDR, 8'h00);
    cyc(3);
    chkBit(ringOscEn, 1'b1);
    wr(ccsm_pkg::PCLK_ADDR, 8'h10);
    cyc(20);
    rdchk(ccsm_pkg::PCLK_ADDR, 8'h30);
    wr(ccsm_pkg::MODE_ADDR, 8'h00);
    rdchk(ccsm_pkg::MODE_ADDR, 8'h03);
    wr(ccsm_pkg::PCLK_ADDR, 8'h90);
    cyc(3);
    chkBit(mainOscEn, 1'b0);
    req(3'h2);
    cyc(2);
    chk({5'h00, cpuMode}, {5'h00, ccsm_pkg::ST_RUN});
    req(3'h1);
    waitMode(ccsm_pkg::ST_HALT, 4);
    cyc(3);
    chkBit(wdogClkEn, 1'b0);
    chkBit(cpuClkEn, 1'b0);
    chkBit(ringOscEn, 1'b1);
    req(3'h4);
    waitMode(ccsm_pkg::ST_RUN, 4);
    rdchk(ccsm_pkg::PCLK_ADDR, 8'hb0);
    wr(ccsm_pkg::PCLK_ADDR, 8'h00);
    cyc(10);
    rdchk(ccsm_pkg::PCLK_ADDR, 8'h00);
    wr(ccsm_pkg::WSEL_ADDR, 8'h01);
    wr(ccsm_pkg::WDCLR_ADDR, 8'h00);
    req(3'h2);
    waitMode(ccsm_pkg::ST_STOP, 4);
    cyc(2);
    chkBit(wdogClkEn | mainOscEn, 1'b0);
    req(3'h4);
    waitMode(ccsm_pkg::ST_STABW, 4);
    waitMode(ccsm_pkg::ST_RUN, 3000);
    chkBit(n >= 2040, 1'b1);
    rdchk(ccsm_pkg::MODE_ADDR, 8'h03);
    wr(ccsm_pkg::MODE_ADDR, 8'h00);
    cyc(20);
    rdchk(ccsm_pkg::MODE_ADDR, 8'h00);
    req(3'h2);
    waitMode(ccsm_pkg::ST_STOP, 4);
    cyc(3);
    chkBit(ringOscEn, 1'b1);
    req(3'h4);
    waitMode(ccsm_pkg::ST_RUN, 4);
    rdchk(ccsm_pkg::WSTA_ADDR, 8'h00);
    wr(ccsm_pkg::WDCLR_ADDR, 8'h00);
    cyc(2100);
    rdchk(ccsm_pkg::WSTA_ADDR, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(ccsm_pkg::MODE_ADDR, 8'h01);
      @(posedge clock);
      rstSrc <= 4'h1 << i;
      @(posedge clock);
      rstSrc <= 4'h0;
      #1 chk({5'h00, cpuMode}, {5'h00, ccsm_pkg::ST_RESET});
      waitMode(ccsm_pkg::ST_RUN, 400);
      rdchk(ccsm_pkg::MODE_ADDR, 8'h00);
    end
    n = 0;
    while (wdogReset !== 1'b1 && n < 6000) begin
      cyc(1);
      n++;
    end
    chkBit(wdogReset, 1'b1);
    cyc(1);
    chk({5'h00, cpuMode}, {5'h00, ccsm_pkg::ST_RESET});
    finish_test();
  end
endmodule
`default_nettype wire
